// ---- hw/dac_host_pkg.sv ----
// constants for the host controller of a quad 12-bit parallel-load converter
// assumes the converter pins are wired straight to the host ports
// Notes on behaviour
// - data word is 12 bits straight binary, bit 0 lsb, bit 11 msb.
// - host drives read/write high to read, low to write.
// - channel_pair_select high picks C or D, low picks A or B.
// - channel_odd_select high picks B or D, low picks A or C.
package dac_host_pkg;
  localparam int DATA_W = 12;
  localparam int CHAN_W = 2;
  localparam int CLK_NS = 50;
  // bus timing, held in nanoseconds and rounded up to whole cycles
  localparam int SETUP_NS = 100;
  localparam int STROBE_NS = 150;
  localparam int HOLD_NS = 50;
  localparam int LOAD_NS = 150;
  localparam int SETUP_CYC = (SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int LOAD_CYC = (LOAD_NS + CLK_NS - 1) / CLK_NS;
  // plain default: strobe cycles a read may wait for a settled word
  localparam int SETTLE_CYC = 8;
  localparam int CNT_W = 4;
  localparam logic READ_LEVEL = 1'b1;
  localparam logic WRITE_LEVEL = 1'b0;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SETUP = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD = 3'b011,
    ST_LOAD = 3'b100
  } state_t;
endpackage

// ---- hw/dac_host.sv ----
// host controller driving the converter's parallel pins
// assumes pins are wired directly; bus read data passes a 3-flop sampler
`timescale 1ns/1ns
module dac_host
  import dac_host_pkg::*;
#(
  // phase lengths in clock cycles
  parameter int SETUP_N = SETUP_CYC,
  parameter int STROBE_N = STROBE_CYC,
  parameter int HOLD_N = HOLD_CYC,
  parameter int LOAD_N = LOAD_CYC,
  // strobe cycles a read may wait for a settled word, below 2**CNT_W
  parameter int SETTLE_N = SETTLE_CYC
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // user request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_read,
  input wire logic [CHAN_W-1:0] req_chan,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic load_req,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  // converter pins
  output logic chip_select_n,
  output logic read_write,
  output logic channel_pair_select,
  output logic channel_odd_select,
  output logic load_outputs_n,
  output logic dev_reset_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe
);
  // every flop of the controller lives in this one record
  typedef struct packed {
    state_t st;
    logic [CNT_W-1:0] cnt;
    logic rd;
    logic [CHAN_W-1:0] ch;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] rdata;
    logic rsp;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic rst_done;
    logic strobe;
    logic loading;
    logic drive;
  } regs_t;
  regs_t r_q;
  regs_t r_d;

  // pin levels that each state asks for
  typedef struct packed {
    logic strobe;
    logic loading;
    logic bus;
  } pins_t;

  logic [DATA_W-1:0] bit_agree;
  logic settled;
  logic setup_end;
  logic strobe_min;
  logic settle_out;
  logic hold_end;
  logic load_end;
  logic can_start;
  pins_t next_pins;

  // true on the last cycle of a phase that lasts n cycles
  function automatic logic last_cycle(logic [CNT_W-1:0] c, int n);
    return c == CNT_W'(n - 1);
  endfunction

  // true once a phase has run for at least n cycles
  function automatic logic reached(logic [CNT_W-1:0] c, int n);
    return c >= CNT_W'(n - 1);
  endfunction

  // on writes only, host owns the bus from setup to hold, so it never races the device
  function automatic pins_t pins_for(state_t s);
    pins_t p;
    p = '0;
    case (s)
      ST_SETUP: begin
        p.bus = 1'b1;
      end
      ST_STROBE: begin
        p.strobe = 1'b1;
        p.bus = 1'b1;
      end
      ST_HOLD: begin
        p.bus = 1'b1;
      end
      ST_LOAD: begin
        p.loading = 1'b1;
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction

  // each bit is settled once the last two sampler stages agree
  for (genvar b = 0; b < DATA_W; b++) begin : g_agree
    assign bit_agree[b] = (r_q.s2[b] == r_q.s3[b]);
  end

  assign settled = &bit_agree;
  assign setup_end = last_cycle(r_q.cnt, SETUP_N);
  assign strobe_min = reached(r_q.cnt, STROBE_N);
  // a bus that never settles yields the last stage rather than a hang
  assign settle_out = reached(r_q.cnt, SETTLE_N);
  assign hold_end = last_cycle(r_q.cnt, HOLD_N);
  assign load_end = last_cycle(r_q.cnt, LOAD_N);
  assign can_start = r_q.rst_done && !load_req;

  always_comb begin
    r_d = r_q;
    next_pins = '0;
    r_d.rsp = 1'b0;
    // sampler: second and third stages agreeing marks a settled bus
    r_d.s1 = data_in;
    r_d.s2 = r_q.s1;
    r_d.s3 = r_q.s2;
    r_d.rst_done = 1'b1;
    case (r_q.st)
      ST_IDLE: begin
        r_d.cnt = '0;
        if (load_req && r_q.rst_done) begin
          r_d.st = ST_LOAD;
        end else if (req_valid && can_start) begin
          r_d.rd = req_read;
          r_d.ch = req_chan;
          r_d.wdata = req_data;
          r_d.st = ST_SETUP;
        end
      end
      ST_SETUP: begin
        r_d.cnt = r_q.cnt + 1'b1;
        if (setup_end) begin
          r_d.cnt = '0;
          r_d.st = ST_STROBE;
        end
      end
      ST_STROBE: begin
        // read needs extra cycles so the sampler sees a settled word
        r_d.cnt = r_q.cnt + 1'b1;
        if (strobe_min && (!r_q.rd || settled || settle_out)) begin
          r_d.cnt = '0;
          if (r_q.rd) begin
            r_d.rdata = r_q.s3;
            r_d.rsp = 1'b1;
          end
          r_d.st = ST_HOLD;
        end
      end
      ST_HOLD: begin
        // data and selects stay put so the closing latch edge sees them
        r_d.cnt = r_q.cnt + 1'b1;
        if (hold_end) begin
          r_d.cnt = '0;
          r_d.st = ST_IDLE;
        end
      end
      ST_LOAD: begin
        // outputs update together; no bus transfer overlaps this
        r_d.cnt = r_q.cnt + 1'b1;
        if (load_end) begin
          r_d.cnt = '0;
          r_d.st = ST_IDLE;
        end
      end
      default: begin
        r_d.cnt = '0;
        r_d.st = ST_IDLE;
      end
    endcase
    // pin strobes come straight from flops: decoding the state on the pin
    // could glitch a latch enable open while several state bits change
    next_pins = pins_for(r_d.st);
    r_d.strobe = next_pins.strobe;
    r_d.loading = next_pins.loading;
    r_d.drive = next_pins.bus && !r_d.rd;
  end

  always_ff @(posedge clk) begin
    // reset clears every flop: pins rest idle and the device stays reset
    if (!rst_n) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  // handshake outputs may follow the state directly
  assign req_ready = (r_q.st == ST_IDLE) && can_start;
  assign rsp_valid = r_q.rsp;
  assign rsp_data = r_q.rdata;

  // our reset drives the device reset so all its registers take reset code
  assign dev_reset_n = r_q.rst_done;
  // chip select low only in strobe; setup and hold keep the latch closed
  assign chip_select_n = !r_q.strobe;
  assign read_write = r_q.rd ? READ_LEVEL : WRITE_LEVEL;
  assign channel_pair_select = r_q.ch[CHAN_W-1];
  assign channel_odd_select = r_q.ch[0];
  // all four output registers follow their inputs while this is low
  assign load_outputs_n = !r_q.loading;
  assign data_out = r_q.wdata;
  // drive bus only for writes, never while the device may read back
  assign data_oe = r_q.drive;
endmodule

// ---- bench/dac_dev_model.sv ----
// behavioural quad converter register file
// assumes pins come straight from the host controller
`timescale 1ns/1ns
module dac_dev_model import dac_host_pkg::*; #(
  parameter logic [11:0] RST_CODE = 12'h800) (
  input wire logic cs_n, rw, sel1, sel0, ld_n, rst_n,
  input wire logic [11:0] bus,
  output logic [11:0] rd,
  output logic [3:0][11:0] dac);
  logic [3:0][11:0] inr;
  always @* begin
    if (!rst_n) begin
      inr = {4{RST_CODE}};
      dac = {4{RST_CODE}};
    end else begin
      if (!cs_n && !rw) inr[{sel1, sel0}] = bus;
      if (!ld_n) dac = inr;
    end
  end
  // released bus shows the inverse so stale data never reads back
  assign rd = (!cs_n && rw) ? inr[{sel1, sel0}] : ~bus;
endmodule

// ---- bench/dac_host_asserts.sv ----
// pin checks for the host controller
// assumes bound to dac_host
`timescale 1ns/1ns
module dac_host_chk import dac_host_pkg::*; (
  input wire logic clk, rst_n, req_valid, req_ready, req_read, data_oe,
  input wire logic [1:0] req_chan,
  input wire logic [11:0] req_data, data_out,
  input wire logic chip_select_n, read_write, rsp_valid, load_outputs_n,
  input wire logic channel_pair_select, channel_odd_select);
  logic [14:0] q;
  always_ff @(posedge clk)
    if (req_valid && req_ready) q <= {req_read, req_chan, req_data};
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_pair_sel: assert property (
    !chip_select_n |-> channel_pair_select == q[13]) else $error("pair");
  a_odd_sel: assert property (
    !chip_select_n |-> channel_odd_select == q[12]) else $error("odd");
  a_rw_level: assert property (
    !chip_select_n |-> read_write == q[14] && data_oe == !q[14])
    else $error("rw");
  a_write_word: assert property (
    !chip_select_n && !read_write |-> data_out == q[11:0]) else $error("word");
  cover property (rsp_valid);
  cover property (!load_outputs_n);
  cover property (!chip_select_n && !read_write);
endmodule
bind dac_host dac_host_chk u_chk (.*);

// ---- bench/testbench.sv ----
// scenarios for the converter host controller
// assumes the device model sits on the pins
`timescale 1ns/1ns
module testbench import dac_host_pkg::*;;
  logic clk = 0, rst_n = 0, req_valid = 0, req_read = 0, load_req = 0;
  logic [1:0] req_chan = 0;
  logic [11:0] req_data = 0, rsp_data, data_out, rd;
  logic req_ready, rsp_valid, cs_n, rw, s1, s0, ld_n, dr_n, oe;
  logic [3:0][11:0] dac;
  logic [3:0][11:0] v = {12'h7fe, 12'h800, 12'hfff, 12'h001};
  int mismatches = 0, comparisons = 0;
  initial forever #25 clk = ~clk;
  dac_host DUT (.clk, .rst_n, .req_valid, .req_ready, .req_read, .req_chan,
    .req_data, .load_req, .rsp_valid, .rsp_data, .chip_select_n(cs_n),
    .read_write(rw), .channel_pair_select(s1), .channel_odd_select(s0),
    .load_outputs_n(ld_n), .dev_reset_n(dr_n),
    .data_in(oe ? data_out : rd), .data_out, .data_oe(oe));
  dac_dev_model dev (.cs_n, .rw, .sel1(s1), .sel0(s0), .ld_n, .rst_n(dr_n),
    .bus(data_out), .rd, .dac);
  task automatic conclude();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(string n, logic [11:0] s, logic [11:0] e);
    comparisons++;
    if (s !== e) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic waitfor(ref logic f);
    int i;
    for (i = 0; i < 60 && f !== 1'b1; i++) @(negedge clk);
    if (f !== 1'b1) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic go(logic r, logic [1:0] c, logic [11:0] d, logic ld);
    waitfor(req_ready);
    {req_valid, req_read, req_chan, req_data, load_req} = {!ld, r, c, d, ld};
    @(negedge clk);
    {req_valid, load_req} = 0;
  endtask
  task automatic rdc(logic [1:0] c, logic [11:0] e);
    go(1, c, 0, 0);
    waitfor(rsp_valid);
    chk("readback", rsp_data, e);
  endtask
  task automatic t_reset();
    for (int c = 0; c < 4; c++) rdc(c, 12'h800);
    $display("reset test done");
  endtask
  task automatic t_write_load();
    for (int c = 0; c < 4; c++) go(0, c, v[c], 0);
    for (int c = 0; c < 4; c++) rdc(c, v[c]);
    chk("held output", dac[3], 12'h800);
    go(0, 0, 0, 1);
    repeat (5) @(negedge clk);
    for (int c = 0; c < 4; c++) chk("output", dac[c], v[c]);
    $display("write and load test done");
  endtask
  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1;
    t_reset();
    t_write_load();
    conclude();
  end
endmodule
